/* File: shared/printer_defines.svh */
// Constants for the dot-matrix printer sequencer.
`ifndef PRINTER_DEFINES_SVH
`define PRINTER_DEFINES_SVH

// -------------------------------------------------------------------------
// Geometry
// -------------------------------------------------------------------------
`define ROWS          7
`define COLS          5
`define LINE_CHARS    40
`define ADDR_W        6
`define CHAR_W        8
`define END_LINE_CHAR 8'h0d

// -------------------------------------------------------------------------
// Timing
// -------------------------------------------------------------------------
`define CLK_NS        50
`define PULSE_NS      400000
`define GAP_NS        900000
`define PULSE_CYC     ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_CYC       ((`GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W         15

// -------------------------------------------------------------------------
// Status bits
// -------------------------------------------------------------------------
`define ST_FULL_BIT   0
`define ST_PRINT_BIT  1
`define ST_FEED_BIT   2
`define ST_DONE_BIT   3

`endif

/* File: shared/printer_pkg.sv */
// Types shared by the printer sequencer modules.
package printer_pkg;
  // Sequencer states, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_HOME = 5'b00010,
    ST_FIRE = 5'b00100,
    ST_GAP  = 5'b01000,
    ST_FEED = 5'b10000
  } seq_state_t;
endpackage : printer_pkg

/* File: shared/line_buf_if.sv */
// Carrier between the sequencer and its line memory.
`timescale 1ns/1ns
`default_nettype none
`include "printer_defines.svh"
interface line_buf_if;
  logic                 wr_en;    // Write strobe.
  logic [`ADDR_W-1:0]   wr_addr;  // Write position.
  logic [`CHAR_W-1:0]   wr_data;  // Character written.
  logic [`ADDR_W-1:0]   rd_addr;  // Read position.
  logic [`CHAR_W-1:0]   rd_data;  // Registered read data.
  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : line_buf_if
`default_nettype wire

/* File: logic/line_buf_mem.sv */
// Forty-character line memory with registered read.
`timescale 1ns/1ns
`default_nettype none
`include "printer_defines.svh"
module line_buf_mem (
  input  wire logic sys_clk_i,
  line_buf_if.mem   bus
);
  // Storage holds one full line of characters.
  logic [`CHAR_W-1:0] mem_r [0:`LINE_CHARS-1];  // Character cells.

  // -----------------------------------------------------------------------
  // Write port.
  // -----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (bus.wr_en) begin
      mem_r[bus.wr_addr] <= bus.wr_data;
    end
  end

  // -----------------------------------------------------------------------
  // Read port, registered so that the data lands one cycle after the address.
  // -----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    bus.rd_data <= mem_r[bus.rd_addr];
  end
endmodule : line_buf_mem
`default_nettype wire

/* File: logic/dot_matrix_printer_sequencer.sv */
// Sequencer that prints one line per head stroke on a seven-wire printer.
`timescale 1ns/1ns
`default_nettype none
`include "printer_defines.svh"
module dot_matrix_printer_sequencer
  import printer_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = `PULSE_CYC,  // Dot pulse length.
  parameter int unsigned GAP_CYCLES   = `GAP_CYC     // Pause after a dot.
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 rstn_i,
  input  wire logic                 host_wr_i,
  input  wire logic [`CHAR_W-1:0]   host_data_i,
  input  wire logic                 host_stat_rd_i,
  output logic      [3:0]           status_o,
  output logic                      irq_o,
  input  wire logic                 sense_input_0_i,
  input  wire logic                 sense_input_1_i,
  output logic      [`ROWS-1:0]     solenoid_o,
  output logic                      main_motor_o,
  output logic                      feed_motor_o
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  line_buf_if lb ();                         // Line memory carrier.
  seq_state_t             state_r;           // Sequencer state.
  seq_state_t             state_nxt;         // Next sequencer state.
  logic [`CHAR_W-1:0]     data_r;            // Host data register.
  logic                   full_r;            // Data register holds a byte.
  logic                   done_r;            // Line finished, sticky.
  logic [`ADDR_W-1:0]     fill_r;            // Characters stored so far.
  logic                   line_ready_r;      // Whole line is in memory.
  logic [`ADDR_W-1:0]     chr_r;             // Character being printed.
  logic [2:0]             col_r;             // Column inside the character.
  logic [`CNT_W-1:0]      cnt_r;             // Pulse and pause timer.
  logic                   home_prev_r;       // Head-return switch, last cycle.
  logic                   adv_prev_r;        // Advance switch, last cycle.
  logic                   adv_seen_r;        // Advance switch was seen on.
  logic                   take;              // Move data register into memory.
  logic                   home_fall;         // Head-return trailing edge.
  logic                   adv_fall;          // Advance trailing edge.
  logic                   col_last;          // Last column of last character.
  logic [2:0]             fire_col;          // Column that the next pulse prints.

  // Arbitrary column pattern generator: a full font table would not fit.
  function automatic logic [`ROWS-1:0] col_pattern(input logic [`CHAR_W-1:0] ch,
                                                   input logic [2:0]         col);
    logic [13:0] dbl;
    dbl = {ch[6:0], ch[6:0]};
    col_pattern = dbl[col +: 7];
  endfunction : col_pattern

  line_buf_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .bus       (lb.mem)
  );

  // -----------------------------------------------------------------------
  // Switch sampling and edge detection
  // -----------------------------------------------------------------------
  // The filtered switches are synchronous already; one stage keeps history.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      home_prev_r <= 1'b0;
      adv_prev_r  <= 1'b0;
    end else begin
      home_prev_r <= sense_input_1_i;
      adv_prev_r  <= sense_input_0_i;
    end
  end
  assign home_fall = home_prev_r & ~sense_input_1_i;
  assign adv_fall  = adv_prev_r & ~sense_input_0_i;

  // -----------------------------------------------------------------------
  // Host data register
  // -----------------------------------------------------------------------
  // Bytes are only taken while idle; a write before the take overwrites the held byte.
  assign take = full_r && (state_r == ST_IDLE) && !line_ready_r;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      data_r <= 8'h00;
      full_r <= 1'b0;
    end else if (host_wr_i) begin
      data_r <= host_data_i;
      full_r <= 1'b1;         // A write wins over a take in the same cycle.
    end else if (take) begin
      full_r <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Line fill
  // -----------------------------------------------------------------------
  // A line ends at forty characters or at a carriage return; the return
  // itself is stored as a blank so its own cell, still walked by the head, prints nothing.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      fill_r       <= 6'h00;
      line_ready_r <= 1'b0;
    end else if (take) begin
      if (data_r == `END_LINE_CHAR || fill_r == 6'(`LINE_CHARS - 1)) begin
        line_ready_r <= 1'b1;
      end
      fill_r <= fill_r + 6'h01;
    end else if (state_r == ST_FEED && state_nxt == ST_IDLE) begin
      fill_r       <= 6'h00;
      line_ready_r <= 1'b0;
    end
  end
  assign lb.wr_en   = take;
  assign lb.wr_addr = fill_r;
  assign lb.wr_data = (data_r == `END_LINE_CHAR) ? 8'h00 : data_r;
  // The memory read is registered, so during the pause the address already
  // points at the character of the next pulse; otherwise the first column of
  // each new character would be cut from the previous one.
  assign lb.rd_addr = (state_r == ST_GAP && col_r == 3'(`COLS - 1)) ? chr_r + 6'h01 : chr_r;
  // The column counter only steps as the pulse starts, so look one ahead here.
  assign fire_col   = (state_r == ST_FIRE) ? col_r :
                      (state_r == ST_GAP && col_r != 3'(`COLS - 1)) ? col_r + 3'h1 : 3'h0;

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  assign col_last = (col_r == 3'(`COLS - 1)) && (chr_r == fill_r - 6'h01);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (line_ready_r) begin
          state_nxt = ST_HOME;
        end
      end
      ST_HOME: begin
        if (home_fall) begin
          state_nxt = ST_FIRE;
        end
      end
      ST_FIRE: begin
        if (cnt_r == `CNT_W'(PULSE_CYCLES - 1)) begin
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        if (cnt_r == `CNT_W'(GAP_CYCLES - 1)) begin
          state_nxt = col_last ? ST_FEED : ST_FIRE;
        end
      end
      ST_FEED: begin
        if (adv_seen_r && adv_fall) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Timer restarts at every state change.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || state_nxt != state_r) begin
      cnt_r <= '0;
    end else if (state_r == ST_FIRE || state_r == ST_GAP) begin
      cnt_r <= cnt_r + `CNT_W'(1);
    end
  end

  // Column and character position walk five columns per character.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || state_r == ST_IDLE) begin
      col_r <= 3'h0;
      chr_r <= 6'h00;
    end else if (state_r == ST_GAP && state_nxt == ST_FIRE) begin
      if (col_r == 3'(`COLS - 1)) begin
        col_r <= 3'h0;
        chr_r <= chr_r + 6'h01;
      end else begin
        col_r <= col_r + 3'h1;
      end
    end
  end

  // Remember that the advance switch closed, so only its opening ends feed.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || state_r != ST_FEED) begin
      adv_seen_r <= 1'b0;
    end else if (sense_input_0_i) begin
      adv_seen_r <= 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // Printer outputs
  // -----------------------------------------------------------------------
  // Solenoids are registered and only set in the fire state, whose length
  // is bounded by the timer, so no wire can stay energised.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      solenoid_o <= '0;
    end else if (state_nxt == ST_FIRE) begin
      solenoid_o <= col_pattern(lb.rd_data, fire_col);
    end else begin
      solenoid_o <= '0;
    end
  end

  // Motors follow the state; the feed motor drops with the switch opening.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      main_motor_o <= 1'b0;
      feed_motor_o <= 1'b0;
    end else begin
      main_motor_o <= (state_nxt != ST_IDLE);
      feed_motor_o <= (state_nxt == ST_FEED);
    end
  end

  // -----------------------------------------------------------------------
  // Status and interrupt
  // -----------------------------------------------------------------------
  // Line done is set at the end of feed and cleared by a status read;
  // the set wins if both happen together.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      done_r <= 1'b0;
    end else if (state_r == ST_FEED && state_nxt == ST_IDLE) begin
      done_r <= 1'b1;
    end else if (host_stat_rd_i) begin
      done_r <= 1'b0;
    end
  end
  assign irq_o = done_r;
  assign status_o[`ST_FULL_BIT]  = full_r;
  assign status_o[`ST_PRINT_BIT] = line_ready_r;
  assign status_o[`ST_FEED_BIT]  = feed_motor_o;
  assign status_o[`ST_DONE_BIT]  = done_r;

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  logic [`CNT_W-1:0] on_cnt_r;  // Cycles a solenoid has been on.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || solenoid_o == '0) begin
      on_cnt_r <= '0;
    end else begin
      on_cnt_r <= on_cnt_r + `CNT_W'(1);
    end
  end

  sequence s_pulse_end;
    state_r == ST_FIRE ##1 state_r == ST_GAP;
  endsequence
  sequence s_quiet;
    solenoid_o == '0 [*8];
  endsequence

  a_start_on_home: assert property (state_r == ST_HOME && home_fall |=> state_r == ST_FIRE)
    else $error("head-return edge did not start printing");
  a_feed_stop: assert property (state_r == ST_FEED && adv_seen_r && adv_fall |=> ##1 !feed_motor_o)
    else $error("feed motor not stopped at switch release");
  a_fire_stroke: assert property (solenoid_o != '0 |-> state_r == ST_FIRE)
    else $error("solenoid fired outside print stroke");
  a_col_range: assert property (col_r < 3'(`COLS))
    else $error("column index out of range");
  a_char_range: assert property (chr_r < 6'(`LINE_CHARS) && fill_r <= 6'(`LINE_CHARS))
    else $error("character index out of range");
  a_pulse_bound: assert property (on_cnt_r <= `CNT_W'(PULSE_CYCLES))
    else $error("solenoid held on too long");
  a_pause_after: assert property (s_pulse_end |-> s_quiet)
    else $error("no pause after dot pulse");
  a_irq_on_done: assert property (state_r == ST_FEED && state_nxt == ST_IDLE |=> irq_o)
    else $error("interrupt not raised at line end");
  a_status_full: assert property (host_wr_i |=> status_o[`ST_FULL_BIT] && data_r == $past(host_data_i))
    else $error("status full bit missed a host write");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn_i |=> solenoid_o == '0 && !irq_o && !main_motor_o && !feed_motor_o)
    else $error("outputs active after reset");
endmodule : dot_matrix_printer_sequencer
`default_nettype wire

/* File: dv/printer_model.sv */
// Behavioural printer: head-return cam switch and paper-advance switch.
`timescale 1ns/1ns
`default_nettype none
module printer_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [7:0] delay_i,         // Cycles before a switch closes.
  input  wire logic       main_motor_i,    // Main drive enable.
  input  wire logic       feed_motor_i,    // Paper-advance motor enable.
  output logic            sense_input_0_o, // Paper-advance switch, high = closed.
  output logic            sense_input_1_o  // Head-return switch, high = closed.
);
  logic [8:0] home_cnt_r; // Cycles since the main drive started.
  logic [8:0] feed_cnt_r; // Cycles since the advance motor started.

  // -------------------------------------------------------------------------
  // Head-return cam
  // -------------------------------------------------------------------------
  // One return stroke per drive start; the counter parks so the cam fires once.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !main_motor_i) begin
      home_cnt_r      <= 9'h000;
      sense_input_1_o <= 1'b0;
    end else if (home_cnt_r != 9'h1ff) begin
      home_cnt_r      <= home_cnt_r + 9'h001;
      sense_input_1_o <= home_cnt_r >= {1'b0, delay_i} && home_cnt_r < {1'b0, delay_i} + 9'h004;
    end
  end

  // -------------------------------------------------------------------------
  // Paper-advance switch
  // -------------------------------------------------------------------------
  // Closed only while paper actually moves, then released.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !feed_motor_i) begin
      feed_cnt_r      <= 9'h000;
      sense_input_0_o <= 1'b0;
    end else if (feed_cnt_r != 9'h1ff) begin
      feed_cnt_r      <= feed_cnt_r + 9'h001;
      sense_input_0_o <= feed_cnt_r >= {1'b0, delay_i} && feed_cnt_r < {1'b0, delay_i} + 9'h005;
    end
  end
endmodule : printer_model
`default_nettype wire

/* File: dv/tb_dot_matrix_printer_sequencer.sv */
// Self-checking bench for the printer sequencer against a printer model.
`timescale 1ns/1ns
`default_nettype none
`include "printer_defines.svh"
module tb_dot_matrix_printer_sequencer;
  localparam int unsigned PULSE = 4; // Shortened dot pulse.
  localparam int unsigned GAP   = 10; // Shortened pause, long enough for the quiet check.
  logic               sys_clk_i, rstn_i, host_wr_i, host_stat_rd_i;
  logic [`CHAR_W-1:0] host_data_i;
  logic [3:0]         status_o;
  logic               irq_o, sense0, sense1, main_motor_o, feed_motor_o;
  logic [`ROWS-1:0]   solenoid_o;
  logic [7:0]         delay;
  int                 mismatches = 0, checked = 0, pulses = 0, run_len = 0, gap_len = 1000;

  dot_matrix_printer_sequencer #(.PULSE_CYCLES(PULSE), .GAP_CYCLES(GAP))
    dot_matrix_printer_sequencer_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .host_wr_i(host_wr_i), .host_data_i(host_data_i), .host_stat_rd_i(host_stat_rd_i),
    .status_o(status_o), .irq_o(irq_o), .sense_input_0_i(sense0),
    .sense_input_1_i(sense1), .solenoid_o(solenoid_o), .main_motor_o(main_motor_o),
    .feed_motor_o(feed_motor_o));
  printer_model printer_model_i (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .delay_i(delay),
    .main_motor_i(main_motor_o), .feed_motor_i(feed_motor_o),
    .sense_input_0_o(sense0), .sense_input_1_o(sense1));

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  // -------------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("Counts: %0d compared, %0d mismatched", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // Condition table for the bounded waits below.
  function automatic logic cond(input int which);
    case (which)
      0: return status_o[0] === 1'b0;
      1: return status_o[1] === 1'b1;
      2: return sense1 === 1'b1;
      3: return sense1 === 1'b0;
      4: return solenoid_o !== '0;
      5: return feed_motor_o === 1'b1;
      6: return feed_motor_o === 1'b0;
      7: return sense0 === 1'b1;
      default: return sense0 === 1'b0;
    endcase
  endfunction : cond

  // Counts falling edges until the condition holds; a hang ends the run.
  task automatic wait_until(input int which, input int limit, output int n);
    n = 0;
    while (!cond(which) && n < limit) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (!cond(which)) begin
      mismatches++;
      final_report();
    end
  endtask : wait_until

  task automatic do_reset(input int cycles);
    rstn_i <= 1'b0;
    repeat (cycles) @(negedge sys_clk_i);
    check({irq_o, main_motor_o, feed_motor_o, solenoid_o, status_o}, '0);
    rstn_i <= 1'b1;
    @(negedge sys_clk_i);
  endtask : do_reset

  // Host may only write once the data register has been emptied.
  task automatic put_byte(input logic [7:0] b);
    int n;
    wait_until(0, 50, n);
    host_data_i <= b;
    host_wr_i   <= 1'b1;
    @(negedge sys_clk_i);
    host_wr_i <= 1'b0;
    check(status_o[0], 1'b1);
    @(negedge sys_clk_i);
  endtask : put_byte

  // -------------------------------------------------------------------------
  // Solenoid monitor
  // -------------------------------------------------------------------------
  // Every pulse must be exact, separated by a full pause, and never on the return.
  always @(negedge sys_clk_i) begin
    if (!rstn_i) begin
      run_len = 0;
    end else if (solenoid_o !== '0) begin
      if (run_len == 0) begin
        pulses++;
        if (gap_len < GAP) check(gap_len, GAP);
      end
      run_len++;
      if (sense1 === 1'b1) check(solenoid_o, '0);
      if (run_len == PULSE + 1) check(run_len, PULSE);
    end else begin
      if (run_len != 0) check(run_len, PULSE);
      if (run_len != 0) gap_len = 0;
      run_len = 0;
      gap_len++;
    end
  end

  // -------------------------------------------------------------------------
  // Scenario: one line from host bytes to paper advance, optionally cut short
  // -------------------------------------------------------------------------
  task automatic run_line(input int count, input bit term, input logic [7:0] dly,
                          input bit abort);
    int n;
    delay  = dly;
    pulses = 0;
    for (int i = 0; i < count; i++) put_byte(8'h7f);
    if (term) put_byte(`END_LINE_CHAR);
    wait_until(1, 20, n); // Line stored.
    @(negedge sys_clk_i); // Main drive starts one edge after the line is stored.
    check(main_motor_o, 1'b1);
    check(solenoid_o, '0);
    wait_until(2, 300, n);
    wait_until(3, 20, n);
    wait_until(4, 10, n);
    check(n, 1);
    check(solenoid_o, 7'h7f);
    if (abort) begin
      do_reset(2);
      $display("Test reset during printing done");
      return;
    end
    wait_until(5, 4000, n);
    check(pulses, 5 * count);
    check(status_o[2], 1'b1);
    wait_until(7, 300, n);
    check(feed_motor_o, 1'b1);
    wait_until(8, 20, n);
    wait_until(6, 10, n);
    check(n, 1);
    check({irq_o, status_o[3], status_o[2], main_motor_o}, 4'hc);
    host_stat_rd_i <= 1'b1;
    @(negedge sys_clk_i);
    host_stat_rd_i <= 1'b0;
    check({irq_o, status_o[3]}, 2'b00);
    $display("Test line of %0d characters done", count);
  endtask : run_line

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    rstn_i         = 1'b0;
    host_wr_i      = 1'b0;
    host_stat_rd_i = 1'b0;
    host_data_i    = 8'h00;
    delay          = 8'h02;
    do_reset(6);
    run_line(40, 1'b0, 8'h02, 1'b0); // Full line, prompt printer.
    run_line(3, 1'b1, 8'h80, 1'b0);  // Short line, slow printer.
    run_line(2, 1'b1, 8'h10, 1'b1);  // Reset in mid-print.
    run_line(1, 1'b1, 8'h00, 1'b0);  // Single character after recovery.
    final_report();
  end
endmodule : tb_dot_matrix_printer_sequencer
`default_nettype wire
